// >>> rtl/psm_pkg.sv
// Package of the PLC signal map: area codes, area sizes, bit positions,
// reset values and transfer timing.
// Assumes a 40 MHz system clock and byte-wide signal areas.
package psm_pkg;

  // ------------------------------------------------------------------
  // Address layout: area type, decimal byte number, bit number
  // ------------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int AREA_LSB    = 13;
  localparam int BYTE_LSB    = 3;
  localparam int BYTE_W      = 10;

  localparam logic [2:0] AREA_Y = 3'h0;  // Panel indicator outputs
  localparam logic [2:0] AREA_G = 3'h1;  // Control bytes to the kernel
  localparam logic [2:0] AREA_F = 3'h2;  // Status bytes from the kernel
  localparam logic [2:0] AREA_R = 3'h3;  // Internal relays
  localparam logic [2:0] AREA_K = 3'h4;  // Holding relays
  localparam logic [2:0] AREA_A = 3'h5;  // Message requests
  localparam logic [2:0] AREA_C = 3'h6;  // Counter current values

  // ------------------------------------------------------------------
  // Area sizes and special byte numbers
  // ------------------------------------------------------------------
  localparam int Y_FIRST     = 16;
  localparam int Y_BYTES     = 8;
  localparam int G_BYTES     = 64;
  localparam int G_JOG_POS   = 100;
  localparam int G_JOG_NEG   = 102;
  localparam int F_BYTES     = 64;
  localparam int R_BYTES     = 990;
  localparam int R_SYS0      = 990;
  localparam int R_SYS1      = 991;
  localparam int K_BYTES     = 64;
  localparam int K_SYS_LAST  = 5;
  localparam int A_BYTES     = 32;
  localparam int C_BYTES     = 256;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int Y_MODE_BYTE = 0;   // Indicator byte 16
  localparam int Y_SEG_BYTE  = 6;   // Indicator byte 22
  localparam int Y_STAT_BYTE = 7;   // Indicator byte 23
  localparam int G_RAPID     = 14;
  localparam int G_STEP      = 19;
  localparam int G_SPIN      = 26;
  localparam int G_SPJOG     = 29;
  localparam int G_MODE      = 43;
  localparam int K_DEBUG_BYTE = 5;
  localparam int K_DEBUG_BIT  = 2;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam int         PERIOD_US  = 8000;  // Output transfer period
  localparam int         CLK_MHZ    = 40;
  localparam int         PERIOD_CYC = PERIOD_US * CLK_MHZ;

endpackage

// >>> rtl/psm_signal_map.sv
// Signal memory of the ladder engine: all byte areas, the first-scan
// flag, the periodic output transfer and the debug-mode gating.
// Assumes one ladder evaluator port, one kernel port for status bytes,
// and scan start/end pulses from the sequencer, all on clock_i.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - Indicator area is bytes 16 to 23
// - Indicator bytes sent to keyboard after scan
// - Byte 16 bits 1-7 light mode lamps
// - Byte 22 carries BCD seven-segment digit
// - Byte 23: home done, alarm, ready, run
// - Control area is 64 bytes, 0 to 63
// - Control byte 43 holds mode and selects
// - Bytes 100 and 102 request axis jogs
// - Spindle direction in 26, jog shift 29
// - Byte 14 two-bit rapid override code
// - Byte 19 one-hot handwheel step size
// - Status area 64 bytes, kernel writes only
// - Relay area 990 bytes, cleared at power-up
// - Relay 990.0 flags the first scan
// - Holding area 64 bytes, never cleared
// - Holding 5.2 selects debug mode
// - Message area 32 bytes, cleared at power-up
// - Counter current values cleared at power-up
// - Address is area, byte and bit
// - Outputs transferred every 8 ms period
module psm_signal_map #(
  parameter int PERIOD_CYC = psm_pkg::PERIOD_CYC
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic [psm_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  wire logic                        bit_mode_i,
  output logic      [7:0]                  rdata_o,
  output logic                             busy_o,
  input  wire logic                        f_wr_i,
  input  wire logic [5:0]                  f_addr_i,
  input  wire logic [7:0]                  f_data_i,
  input  wire logic                        scan_start_i,
  input  wire logic                        scan_end_i,
  input  wire logic                        alarm_i,
  input  wire logic                        interlock_i,
  input  wire logic                        tool_req_i,
  output logic                             alarm_o,
  output logic                             interlock_o,
  output logic                             tool_go_o,
  output logic                             debug_o,
  output logic                             panel_load_o,
  output logic      [63:0]                 panel_bytes_o,
  output logic      [6:0]                  mode_lamp_o,
  output logic      [7:0]                  seg_bcd_o,
  output logic      [4:0]                  home_done_o,
  output logic                             alarm_lamp_o,
  output logic                             ready_lamp_o,
  output logic                             run_lamp_o,
  output logic      [2:0]                  mode_sel_o,
  output logic                             incr_feed_o,
  output logic                             hw_trial_o,
  output logic                             prog_zero_o,
  output logic                             ref_return_o,
  output logic      [4:0]                  jog_pos_o,
  output logic      [4:0]                  jog_neg_o,
  output logic                             spin_fwd_o,
  output logic                             spin_rev_o,
  output logic                             spin_jog_shift_o,
  output logic      [3:0]                  rapid_sel_o,
  output logic      [2:0]                  hw_step_o,
  output logic                             hw_step_err_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (PERIOD_CYC < 2 || PERIOD_CYC > 1048575) begin : g_bad_period
    $error("PERIOD_CYC out of range");
  end

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [7:0]  y_mem [psm_pkg::Y_BYTES];
  logic [7:0]  g_mem [psm_pkg::G_BYTES];
  logic [7:0]  f_mem [psm_pkg::F_BYTES];
  logic [7:0]  r_mem [psm_pkg::R_BYTES];
  logic [7:0]  k_mem [psm_pkg::K_BYTES];
  logic [7:0]  a_mem [psm_pkg::A_BYTES];
  logic [7:0]  c_mem [psm_pkg::C_BYTES];
  logic [7:0]  jogp_q, jogp_d, jogn_q, jogn_d;
  logic [9:0]  clr_idx_q, clr_idx_d;
  logic        clearing_q, clearing_d;
  logic        first_q, first_d;
  logic [19:0] tick_q, tick_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        load_q, load_d;
  logic [63:0] panel_q, panel_d;
  logic        debug_q, debug_d;
  logic [7:0]  g14_q, g19_q, g26_q, g29_q, g43_q, gp_q, gn_q;
  logic [2:0]  area, bit_no;
  logic [9:0]  byte_no;
  logic        hit, acc_ok;
  logic [7:0]  cur_byte, new_byte;
  logic        do_wr, xfer;
  logic [63:0] y_flat;

  // Mapped-byte decode, shared by read and write paths
  function automatic logic mapped(input logic [2:0] ar, input logic [9:0] bn);
    case (ar)
      psm_pkg::AREA_Y: mapped = bn >= 10'(psm_pkg::Y_FIRST) &&
                                bn < 10'(psm_pkg::Y_FIRST + psm_pkg::Y_BYTES);
      psm_pkg::AREA_G: mapped = bn < 10'(psm_pkg::G_BYTES) || bn == 10'(psm_pkg::G_JOG_POS) ||
                                bn == 10'(psm_pkg::G_JOG_NEG);
      psm_pkg::AREA_F: mapped = bn < 10'(psm_pkg::F_BYTES);
      psm_pkg::AREA_R: mapped = bn <= 10'(psm_pkg::R_SYS1);
      psm_pkg::AREA_K: mapped = bn < 10'(psm_pkg::K_BYTES);
      psm_pkg::AREA_A: mapped = bn < 10'(psm_pkg::A_BYTES);
      psm_pkg::AREA_C: mapped = bn < 10'(psm_pkg::C_BYTES);
      default:         mapped = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Address split and current byte
  // ------------------------------------------------------------------
  // area, byte, bit fields
  assign area    = addr_i[psm_pkg::ADDR_W-1:psm_pkg::AREA_LSB];
  assign byte_no = addr_i[psm_pkg::AREA_LSB-1:psm_pkg::BYTE_LSB];
  assign bit_no  = addr_i[psm_pkg::BYTE_LSB-1:0];
  assign hit     = mapped(area, byte_no);
  assign acc_ok  = hit && !clearing_q;

  // Old byte for reads and bit merges
  always_comb begin
    unique case (area)
      psm_pkg::AREA_Y: cur_byte = y_mem[3'(byte_no - 10'(psm_pkg::Y_FIRST))];
      psm_pkg::AREA_G: begin
        if (byte_no == 10'(psm_pkg::G_JOG_POS)) cur_byte = jogp_q;
        else if (byte_no == 10'(psm_pkg::G_JOG_NEG)) cur_byte = jogn_q;
        else cur_byte = g_mem[byte_no[5:0]];
      end
      psm_pkg::AREA_F: cur_byte = f_mem[byte_no[5:0]];
      psm_pkg::AREA_R: begin
        if (byte_no == 10'(psm_pkg::R_SYS0)) cur_byte = {7'h00, first_q};
        else if (byte_no == 10'(psm_pkg::R_SYS1)) cur_byte = psm_pkg::BYTE_RST;
        else cur_byte = r_mem[byte_no];
      end
      psm_pkg::AREA_K: cur_byte = k_mem[byte_no[5:0]];
      psm_pkg::AREA_A: cur_byte = a_mem[byte_no[4:0]];
      psm_pkg::AREA_C: cur_byte = c_mem[byte_no[7:0]];
      default:         cur_byte = psm_pkg::BYTE_RST;
    endcase
    if (!hit) cur_byte = psm_pkg::BYTE_RST;
  end

  // bit merge or whole-byte write; status and system bytes refused
  always_comb begin
    new_byte = cur_byte;
    if (bit_mode_i) new_byte[bit_no] = wdata_i[0];
    else new_byte = wdata_i;
    do_wr = ce_i && wr_i && acc_ok && area != psm_pkg::AREA_F &&
            !(area == psm_pkg::AREA_R && byte_no >= 10'(psm_pkg::R_SYS0));
  end

  // ------------------------------------------------------------------
  // Area writes
  // ------------------------------------------------------------------
  // ladder-owned bytes; holding bytes have no clear path
  always_ff @(posedge clock_i) begin
    if (do_wr && area == psm_pkg::AREA_Y) y_mem[3'(byte_no - 10'(psm_pkg::Y_FIRST))] <= new_byte;
    if (do_wr && area == psm_pkg::AREA_G && byte_no < 10'(psm_pkg::G_BYTES)) g_mem[byte_no[5:0]] <= new_byte;
    if (do_wr && area == psm_pkg::AREA_K) k_mem[byte_no[5:0]] <= new_byte;
  end

  // status bytes come from the kernel port alone
  always_ff @(posedge clock_i) begin
    if (ce_i && f_wr_i) f_mem[f_addr_i] <= f_data_i;
  end

  // volatile areas swept to zero after reset
  always_ff @(posedge clock_i) begin
    if (ce_i && clearing_q) begin
      if (clr_idx_q < 10'(psm_pkg::R_BYTES)) r_mem[clr_idx_q] <= psm_pkg::BYTE_RST;
      if (clr_idx_q < 10'(psm_pkg::A_BYTES)) a_mem[clr_idx_q[4:0]] <= psm_pkg::BYTE_RST;
      if (clr_idx_q < 10'(psm_pkg::C_BYTES)) c_mem[clr_idx_q[7:0]] <= psm_pkg::BYTE_RST;
    end else begin
      if (do_wr && area == psm_pkg::AREA_R) r_mem[byte_no] <= new_byte;
      if (do_wr && area == psm_pkg::AREA_A) a_mem[byte_no[4:0]] <= new_byte;
      if (do_wr && area == psm_pkg::AREA_C) c_mem[byte_no[7:0]] <= new_byte;
    end
  end

  // ------------------------------------------------------------------
  // Control state: sweep, first scan, read data, transfer
  // ------------------------------------------------------------------
  for (genvar i = 0; i < psm_pkg::Y_BYTES; i++) begin : g_flat
    assign y_flat[8*i +: 8] = y_mem[i];
  end

  // free-running period counter; every scan end also sends
  assign xfer = (tick_q == 20'h00000) || scan_end_i;

  always_comb begin
    clr_idx_d  = clr_idx_q;
    clearing_d = clearing_q;
    first_d    = first_q;
    tick_d     = tick_q;
    rdata_d    = psm_pkg::BYTE_RST;
    load_d     = 1'b0;
    panel_d    = panel_q;
    debug_d    = debug_q;
    jogp_d     = jogp_q;
    jogn_d     = jogn_q;
    // Sweep covers the largest volatile area, then releases the port
    if (clearing_q) begin
      clr_idx_d = clr_idx_q + 10'h001;
      if (clr_idx_q == 10'(psm_pkg::R_BYTES - 1)) clearing_d = 1'b0;
    end
    // set on start, cleared after one full scan; start wins
    if (scan_start_i) first_d = 1'b1;
    else if (scan_end_i) first_d = 1'b0;
    tick_d = (tick_q == 20'(PERIOD_CYC - 1)) ? 20'h00000 : tick_q + 20'h00001;
    if (rd_i && acc_ok) begin
      rdata_d = bit_mode_i ? {7'h00, cur_byte[bit_no]} : cur_byte;
    end
    // jog bytes live outside the 64-byte block
    if (do_wr && area == psm_pkg::AREA_G && byte_no == 10'(psm_pkg::G_JOG_POS)) jogp_d = new_byte;
    if (do_wr && area == psm_pkg::AREA_G && byte_no == 10'(psm_pkg::G_JOG_NEG)) jogn_d = new_byte;
    // snapshot indicators and debug bit at each transfer
    if (xfer) begin
      load_d  = 1'b1;
      panel_d = y_flat;
      debug_d = k_mem[psm_pkg::K_DEBUG_BYTE][psm_pkg::K_DEBUG_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clr_idx_q  <= 10'h000;
      clearing_q <= 1'b1;
      first_q    <= 1'b1;
      tick_q     <= 20'h00001;
      rdata_q    <= 8'h00;
      load_q     <= 1'b0;
      panel_q    <= 64'h0000000000000000;
      debug_q    <= 1'b0;
      jogp_q     <= 8'h00;
      jogn_q     <= 8'h00;
    end else if (ce_i) begin
      clr_idx_q  <= clr_idx_d;
      clearing_q <= clearing_d;
      first_q    <= first_d;
      tick_q     <= tick_d;
      rdata_q    <= rdata_d;
      load_q     <= load_d;
      panel_q    <= panel_d;
      debug_q    <= debug_d;
      jogp_q     <= jogp_d;
      jogn_q     <= jogn_d;
    end
  end

  // Control bytes latched for the kernel at each transfer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      g14_q <= 8'h00; g19_q <= 8'h00; g26_q <= 8'h00; g29_q <= 8'h00;
      g43_q <= 8'h00; gp_q  <= 8'h00; gn_q  <= 8'h00;
    end else if (ce_i && xfer) begin
      g14_q <= g_mem[psm_pkg::G_RAPID]; g19_q <= g_mem[psm_pkg::G_STEP];
      g26_q <= g_mem[psm_pkg::G_SPIN];  g29_q <= g_mem[psm_pkg::G_SPJOG];
      g43_q <= g_mem[psm_pkg::G_MODE];  gp_q  <= jogp_q; gn_q <= jogn_q;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rdata_o       = rdata_q;
  assign busy_o        = clearing_q;
  assign panel_load_o  = load_q;
  assign panel_bytes_o = panel_q;
  assign debug_o       = debug_q;
  // mode key lamps from byte 16 bits 1..7
  assign mode_lamp_o   = panel_q[8*psm_pkg::Y_MODE_BYTE+1 +: 7];
  // BCD digit, coding line n on bit n
  assign seg_bcd_o     = panel_q[8*psm_pkg::Y_SEG_BYTE +: 8];
  // home-done, alarm, ready and run lamps
  assign home_done_o   = panel_q[8*psm_pkg::Y_STAT_BYTE +: 5];
  assign alarm_lamp_o  = panel_q[8*psm_pkg::Y_STAT_BYTE+5];
  assign ready_lamp_o  = panel_q[8*psm_pkg::Y_STAT_BYTE+6];
  assign run_lamp_o    = panel_q[8*psm_pkg::Y_STAT_BYTE+7];
  assign mode_sel_o    = g43_q[2:0];
  assign incr_feed_o   = g43_q[3];
  assign hw_trial_o    = g43_q[4];
  assign prog_zero_o   = g43_q[6];
  assign ref_return_o  = g43_q[7];
  assign jog_pos_o     = gp_q[4:0];
  assign jog_neg_o     = gn_q[4:0];
  assign spin_fwd_o       = g26_q[2];
  assign spin_rev_o       = g26_q[3];
  assign spin_jog_shift_o = g29_q[5];
  // 00 F0, 01 25%, 10 50%, 11 100%, one-hot in that order
  assign rapid_sel_o   = 4'h1 << g14_q[1:0];
  // only a single set bit selects a step; others flag an error
  assign hw_step_o     = $onehot(g19_q[6:4]) ? g19_q[6:4] : 3'h0;
  assign hw_step_err_o = !$onehot(g19_q[6:4]);
  // debug mode masks alarms and interlocks, blocks tool change
  assign alarm_o       = alarm_i && !debug_q;
  assign interlock_o   = interlock_i && !debug_q;
  assign tool_go_o     = tool_req_i && !debug_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_first_set;
    @(posedge clock_i) disable iff (rst_i) ce_i && scan_start_i |=> first_q;
  endproperty
  a_first_set: assert property (p_first_set) else $error("first scan flag not set");
  property p_first_clr;
    @(posedge clock_i) disable iff (rst_i) ce_i && first_q && scan_end_i && !scan_start_i |=> !first_q;
  endproperty
  a_first_clr: assert property (p_first_clr) else $error("first scan flag not cleared");
  property p_clear_busy;
    @(posedge clock_i) $fell(rst_i) |-> busy_o;
  endproperty
  a_clear_busy: assert property (p_clear_busy) else $error("no clear sweep after reset");
  property p_busy_read;
    @(posedge clock_i) disable iff (rst_i) ce_i && busy_o && rd_i |=> rdata_o == 8'h00;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read during sweep not zero");
  property p_unmapped;
    @(posedge clock_i) disable iff (rst_i) ce_i && rd_i && !hit |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_panel;
    @(posedge clock_i) disable iff (rst_i) ce_i && scan_end_i |=> panel_load_o && panel_bytes_o == $past(y_flat);
  endproperty
  a_panel: assert property (p_panel) else $error("indicator bytes not sent");
  property p_tick;
    @(posedge clock_i) disable iff (rst_i) ce_i && tick_q == 20'h00000 |=> panel_load_o;
  endproperty
  a_tick: assert property (p_tick) else $error("periodic transfer missed");
  property p_debug;
    @(posedge clock_i) disable iff (rst_i) debug_o |-> !alarm_o && !interlock_o && !tool_go_o;
  endproperty
  a_debug: assert property (p_debug) else $error("debug mode not gating");
  property p_rapid;
    @(posedge clock_i) disable iff (rst_i) $onehot(rapid_sel_o) && rapid_sel_o[g14_q[1:0]];
  endproperty
  a_rapid: assert property (p_rapid) else $error("rapid code decode wrong");
  property p_step;
    @(posedge clock_i) disable iff (rst_i) hw_step_err_o == (hw_step_o == 3'h0);
  endproperty
  a_step: assert property (p_step) else $error("step select decode wrong");

  c_first:  cover property (@(posedge clock_i) disable iff (rst_i) first_q ##1 !first_q);
  c_debug:  cover property (@(posedge clock_i) disable iff (rst_i) debug_o && tool_req_i);
  c_bitwr:  cover property (@(posedge clock_i) disable iff (rst_i) do_wr && bit_mode_i);
  c_sweep:  cover property (@(posedge clock_i) $fell(busy_o));

endmodule

// >>> tb/psm_kernel_model.sv
// Kernel side model: writes status bytes into the signal map.
// Assumes the bench pulses go_i for one clock per byte; slow_i adds a wait.
`timescale 1ns/1ps
module psm_kernel_model (
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic       slow_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic            f_wr_o = 1'b0,
  output logic      [5:0] f_addr_o = 6'h15,
  output logic      [7:0] f_data_o = 8'hA5
);
  logic go_q = 1'b0;
  // kernel owns status bytes
  // Idle bus toggles, so a stale value never passes for a live one
  always_ff @(posedge clock_i) begin
    go_q   <= go_i & slow_i;
    f_wr_o <= slow_i ? go_q : go_i;
    if (go_i) begin
      f_addr_o <= addr_i;
      f_data_o <= data_i;
    end else if (!go_q) begin
      f_addr_o <= ~f_addr_o;
      f_data_o <= ~f_data_o;
    end
  end
endmodule

// >>> tb/test_psm_signal_map.sv
// Self-checking bench of the signal map: ladder port, kernel port, transfers.
// Assumes the kernel model beside it and a 40 MHz clock.
`timescale 1ns/1ps
module test_psm_signal_map;
  localparam int PER = 20;
  int          seed = 99525;
  int          mismatches = 0;
  int          tests_run = 0;
  int          n;
  int          gn[7] = '{43, 100, 102, 26, 29, 14, 19};
  logic [7:0]  gv[7];
  logic [7:0]  yv[8];
  logic        clock_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, bit_mode_i = 1'b0;
  logic        scan_start_i = 1'b0, scan_end_i = 1'b0, alarm_i = 1'b0, interlock_i = 1'b0, tool_req_i = 1'b0;
  logic        k_go = 1'b0, k_slow = 1'b0, f_wr_i, busy_o, alarm_o, interlock_o, tool_go_o, debug_o;
  logic        panel_load_o, alarm_lamp_o, ready_lamp_o, run_lamp_o, incr_feed_o, hw_trial_o, prog_zero_o;
  logic        ref_return_o, spin_fwd_o, spin_rev_o, spin_jog_shift_o, hw_step_err_o;
  logic [15:0] addr_i = 16'h0000;
  logic [63:0] panel_bytes_o;
  logic [7:0]  wdata_i = 8'h00, k_data = 8'h00, rdata_o, seg_bcd_o, f_data_i, q, kd;
  logic [6:0]  mode_lamp_o;
  logic [5:0]  f_addr_i, k_addr = 6'h00;
  logic [4:0]  home_done_o, jog_pos_o, jog_neg_o;
  logic [3:0]  rapid_sel_o;
  logic [2:0]  mode_sel_o, hw_step_o;

  always #12.5 clock_i = ~clock_i;

  psm_signal_map #(.PERIOD_CYC(PER)) dut (
    .clock_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bit_mode_i, .rdata_o, .busy_o, .f_wr_i,
    .f_addr_i, .f_data_i, .scan_start_i, .scan_end_i, .alarm_i, .interlock_i, .tool_req_i, .alarm_o,
    .interlock_o, .tool_go_o, .debug_o, .panel_load_o, .panel_bytes_o, .mode_lamp_o, .seg_bcd_o,
    .home_done_o, .alarm_lamp_o, .ready_lamp_o, .run_lamp_o, .mode_sel_o, .incr_feed_o, .hw_trial_o,
    .prog_zero_o, .ref_return_o, .jog_pos_o, .jog_neg_o, .spin_fwd_o, .spin_rev_o, .spin_jog_shift_o,
    .rapid_sel_o, .hw_step_o, .hw_step_err_o);

  psm_kernel_model kern (.clock_i, .go_i(k_go), .slow_i(k_slow), .addr_i(k_addr), .data_i(k_data),
    .f_wr_o(f_wr_i), .f_addr_o(f_addr_i), .f_data_o(f_data_i));

  // ------------------------------------------------------------------
  // Tasks and expectation functions
  // ------------------------------------------------------------------
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One ladder access; read data land in q
  task automatic acc(input logic w, input logic b, input logic [2:0] ar, input int bn, input logic [2:0] bi,
                     input logic [7:0] dv);
    @(posedge clock_i);
    wr_i       <= w;
    rd_i       <= ~w;
    bit_mode_i <= b;
    addr_i     <= {ar, bn[9:0], bi};
    wdata_i    <= dv;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask

  task automatic kw(input logic [5:0] a, input logic [7:0] dv);
    @(posedge clock_i);
    k_go   <= 1'b1;
    k_addr <= a;
    k_data <= dv;
    @(posedge clock_i);
    k_go <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic pulse(input logic s);
    @(posedge clock_i);
    if (s) scan_start_i <= 1'b1;
    else scan_end_i <= 1'b1;
    @(posedge clock_i);
    scan_start_i <= 1'b0;
    scan_end_i   <= 1'b0;
    #1;
    if (!s) cmp("panel_load_o", 1, panel_load_o);
  endtask

  // Waits out the power-up sweep; a stuck sweep shows as busy
  task automatic settle();
    for (n = 0; n < 1200 && busy_o !== 1'b0; n++) begin
      @(posedge clock_i);
      #1;
    end
    cmp("busy_o", 0, busy_o);
  endtask

  function automatic logic [3:0] step_exp(input logic [2:0] p);
    return ($countones(p) == 1) ? {1'b0, p} : 4'h8;
  endfunction

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    acc(1, 0, psm_pkg::AREA_K, 5, 0, 8'h00);
    acc(0, 1, psm_pkg::AREA_R, 990, 0, 0); cmp("first_scan", 1, q);
    pulse(0);
    acc(1, 0, psm_pkg::AREA_R, 990, 0, 8'hFF);
    acc(0, 1, psm_pkg::AREA_R, 990, 0, 0); cmp("first_scan", 0, q);
    pulse(1);
    acc(0, 1, psm_pkg::AREA_R, 990, 0, 0); cmp("first_scan", 1, q);
    // Power-up zero, then random byte and bit traffic
    for (int i = 0; i < 8; i++) begin
      n  = 123 * i + {$random(seed)} % 123;  // Distinct relay bytes, all below 990
      kd = 8'($random(seed));
      acc(0, 0, psm_pkg::AREA_R, n, 0, 0); cmp("r_zero", 0, q);
      acc(0, 0, psm_pkg::AREA_A, n % 32, 0, 0); cmp("a_zero", 0, q);
      acc(0, 0, psm_pkg::AREA_C, n % 256, 0, 0); cmp("c_zero", 0, q);
      acc(1, 1, psm_pkg::AREA_R, n, i[2:0], 8'h01);
      acc(0, 0, psm_pkg::AREA_R, n, 0, 0); cmp("r_bit", 8'h01 << i, q);
      acc(1, 0, psm_pkg::AREA_K, 8 + n % 56, 0, kd);
      acc(0, 0, psm_pkg::AREA_K, 8 + n % 56, 0, 0); cmp("k_byte", kd, q);
      k_slow = i[0];
      kw(n[5:0], kd);
      acc(1, 0, psm_pkg::AREA_F, n[5:0], 0, ~kd);
      acc(0, 0, psm_pkg::AREA_F, n[5:0], 0, 0); cmp("f_byte", kd, q);
    end
    acc(1, 0, psm_pkg::AREA_G, 63, 0, 8'h3C);
    acc(0, 0, psm_pkg::AREA_G, 63, 0, 0); cmp("g_last", 8'h3C, q);
    acc(1, 0, psm_pkg::AREA_G, 64, 0, 8'h5A);
    acc(0, 0, psm_pkg::AREA_G, 64, 0, 0); cmp("g_unmapped", 0, q);
    // Every rapid code, step pattern and debug state, with random fields
    for (int i = 0; i < 16; i++) begin
      foreach (gv[j]) gv[j] = 8'($random(seed));
      foreach (yv[j]) yv[j] = 8'($random(seed));
      gv[5][1:0] = i[1:0];
      gv[6][6:4] = i[2:0];
      kd         = 8'($random(seed));
      kd[2]      = i[3];
      foreach (gv[j]) acc(1, 0, psm_pkg::AREA_G, gn[j], 0, gv[j]);
      foreach (yv[j]) acc(1, 0, psm_pkg::AREA_Y, 16 + j, 0, yv[j]);
      acc(1, 0, psm_pkg::AREA_K, 5, 0, kd);
      {alarm_i, interlock_i, tool_req_i} <= 3'($random(seed));
      pulse(0);
      cmp("panel_bytes_o", {yv[7], yv[6], yv[5], yv[4], yv[3], yv[2], yv[1], yv[0]}, panel_bytes_o);
      cmp("mode_lamp_o", yv[0][7:1], mode_lamp_o);
      cmp("seg_bcd_o", yv[6], seg_bcd_o);
      cmp("y23", yv[7], {run_lamp_o, ready_lamp_o, alarm_lamp_o, home_done_o});
      cmp("mode_sel_o", gv[0][2:0], mode_sel_o);
      cmp("g43", {gv[0][7:6], gv[0][4:3]}, {ref_return_o, prog_zero_o, hw_trial_o, incr_feed_o});
      cmp("jog", {gv[1][4:0], gv[2][4:0]}, {jog_pos_o, jog_neg_o});
      cmp("spin", {gv[4][5], gv[3][3:2]}, {spin_jog_shift_o, spin_rev_o, spin_fwd_o});
      cmp("rapid_sel_o", 4'h1 << i[1:0], rapid_sel_o);
      cmp("hw_step", step_exp(i[2:0]), {hw_step_err_o, hw_step_o});
      cmp("debug_o", kd[2], debug_o);
      cmp("gated", {alarm_i, interlock_i, tool_req_i} & {3{~kd[2]}}, {alarm_o, interlock_o, tool_go_o});
    end
    // Warm restart: volatile bytes swept again, holding bytes kept, flag set
    acc(1, 0, psm_pkg::AREA_K, 9, 0, 8'h5A);
    acc(1, 0, psm_pkg::AREA_R, 7, 0, 8'hC3);
    acc(0, 0, psm_pkg::AREA_R, 7, 0, 0); cmp("r_byte", 8'hC3, q);
    pulse(0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    acc(0, 0, psm_pkg::AREA_K, 9, 0, 0); cmp("busy_read", 0, q);
    settle();
    // A write with the clock enable low must leave the byte alone
    ce_i <= 1'b0;
    acc(1, 0, psm_pkg::AREA_K, 9, 0, 8'h77);
    ce_i <= 1'b1;
    acc(0, 0, psm_pkg::AREA_K, 9, 0, 0); cmp("k_kept", 8'h5A, q);
    acc(0, 0, psm_pkg::AREA_R, 7, 0, 0); cmp("r_cleared", 0, q);
    acc(0, 1, psm_pkg::AREA_R, 990, 0, 0); cmp("first_scan", 1, q);
    // Periodic transfer with no scan ends
    for (int k = 0; k < 2; k++) begin
      for (n = 0; n < 40; n++) begin
        @(posedge clock_i);
        #1;
        if (panel_load_o === 1'b1) break;
      end
    end
    cmp("period", PER, n + 1);
    results();
  end

  // Watchdog: the sequence needs roughly 2800 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    results();
  end
endmodule
